/* File: rtl/card_detect_regs.svh */
`ifndef CARD_DETECT_REGS_SVH
`define CARD_DETECT_REGS_SVH
// reset values of the host settings
`define HOT_PLUG_ENABLE_RESET 1'b0
`define DETECT_POLARITY_RESET 1'b1
// polarity encodings
`define POLARITY_HIGH 1'b1
`define POLARITY_LOW 1'b0
// qualifying filter length, in cycles of core_clk
`define DETECT_FILTER_CYCLES 16
`endif

/* File: rtl/card_detect_pkg.sv */
package card_detect_pkg;
  typedef enum logic [2:0] {
    ST_BOOT,
    ST_IDLE,
    ST_INIT,
    ST_REGISTER,
    ST_READY,
    ST_ONCE_DONE
  } card_state_t;
endpackage

/* File: rtl/detect_if.sv */
`timescale 1ns/100ps
interface detect_if;
  logic level;
  logic insert_pulse;
  logic remove_pulse;
  modport filt (output level, output insert_pulse, output remove_pulse);
  modport ctrl (input level, input insert_pulse, input remove_pulse);
endinterface

/* File: rtl/detect_filter.sv */
`timescale 1ns/100ps
`include "card_detect_regs.svh"
module detect_filter #(
  parameter int FILTER_CYCLES = `DETECT_FILTER_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic raw_in,
  input wire logic polarity,
  detect_if.filt det
);
  localparam int CW = $clog2(FILTER_CYCLES + 1);
  localparam logic [CW-1:0] CNT_MAX = CW'(FILTER_CYCLES - 1);
  logic sync1_reg, sync2_reg;
  logic level_reg, ins_reg, rem_reg;
  logic [CW-1:0] cnt_reg;
  wire logic active_w = (polarity == `POLARITY_HIGH) ? sync2_reg : ~sync2_reg;
  wire logic differs_w = active_w != level_reg;
  wire logic settle_w = differs_w && (cnt_reg == CNT_MAX);
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
    end else begin
      sync1_reg <= raw_in;
      sync2_reg <= sync1_reg;
    end
  end
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cnt_reg <= '0;
      level_reg <= 1'b0;
      ins_reg <= 1'b0;
      rem_reg <= 1'b0;
    end else begin
      cnt_reg <= (differs_w && !settle_w) ? cnt_reg + CW'(1) : '0;
      if (settle_w) begin
        level_reg <= active_w;
      end
      ins_reg <= settle_w && active_w;
      rem_reg <= settle_w && !active_w;
    end
  end
  assign det.level = level_reg;
  assign det.insert_pulse = ins_reg;
  assign det.remove_pulse = rem_reg;
endmodule

/* File: rtl/card_presence_ctrl.sv */
`timescale 1ns/100ps
`include "card_detect_regs.svh"
module card_presence_ctrl
  import card_detect_pkg::*;
#(
  parameter int FILTER_CYCLES = `DETECT_FILTER_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic card_detect_in,
  input wire logic hot_plug_detect_enable_cmd,
  input wire logic hot_plug_detect_enable_val,
  input wire logic vendor_setting_cmd,
  input wire logic detect_polarity_select,
  input wire logic init_done,
  output logic card_init_start,
  output logic card_read_enable,
  output logic net_register_req,
  output logic card_present,
  output logic card_inserted_evt,
  output logic card_removed_evt,
  output logic hot_plug_enabled,
  output logic polarity_high
);
  detect_if det();
  card_state_t state_reg;
  card_state_t state_next;
  logic enable_reg;
  logic enable_next;
  logic polarity_reg;
  logic polarity_next;
  logic start_reg;
  logic start_next;
  logic read_reg;
  logic read_next;
  logic regreq_reg;
  logic regreq_next;
  logic present_reg;
  logic present_next;
  logic ins_evt_reg;
  logic ins_evt_next;
  logic rem_evt_reg;
  logic rem_evt_next;

  // the slot pin is asynchronous; the filter synchronises and qualifies it
  // filter works in the active sense, so a polarity change alone can raise an event
  detect_filter #(
    .FILTER_CYCLES(FILTER_CYCLES)
  ) u_filter (
    .core_clk(core_clk),
    .rst(rst),
    .raw_in(card_detect_in),
    .polarity(polarity_reg),
    .det(det)
  );
  // qualified level and its one-cycle change pulses
  wire logic level_w = det.level;
  wire logic insert_w = det.insert_pulse;
  wire logic remove_w = det.remove_pulse;

  // host settings: a command loads its value, otherwise the setting holds
  assign enable_next = hot_plug_detect_enable_cmd ? hot_plug_detect_enable_val : enable_reg;
  assign polarity_next = vendor_setting_cmd ? detect_polarity_select : polarity_reg;
  always_ff @(posedge core_clk) begin
    if (rst) begin
      enable_reg <= `HOT_PLUG_ENABLE_RESET;
    end else begin
      enable_reg <= enable_next;
    end
  end
  always_ff @(posedge core_clk) begin
    if (rst) begin
      polarity_reg <= `DETECT_POLARITY_RESET;
    end else begin
      polarity_reg <= polarity_next;
    end
  end

  // state decode
  wire logic in_boot_w = (state_reg == ST_BOOT);
  wire logic in_idle_w = (state_reg == ST_IDLE);
  wire logic in_init_w = (state_reg == ST_INIT);
  wire logic in_register_w = (state_reg == ST_REGISTER);
  wire logic next_init_w = (state_next == ST_INIT);
  wire logic next_register_w = (state_next == ST_REGISTER);
  wire logic next_ready_w = (state_next == ST_READY);
  // in enabled mode the qualified level decides presence
  wire logic go_insert_w = enable_reg && (insert_w || level_w);
  wire logic go_remove_w = enable_reg && !level_w;
  // a read under way when detection is switched off runs on to the end
  wire logic mid_read_w = in_boot_w || in_init_w || in_register_w;
  wire logic hold_disabled_w = !enable_reg && !mid_read_w;

  // card state machine
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_BOOT: begin
        // enable still holds its reset value here, so start-up always reads once
        if (enable_reg) begin
          state_next = ST_IDLE;
        end else begin
          state_next = ST_INIT;
        end
      end
      ST_IDLE: begin
        // a level already active when detection is enabled counts as an insertion
        if (go_insert_w) begin
          state_next = ST_INIT;
        end
      end
      ST_INIT: begin
        if (go_remove_w) begin
          state_next = ST_IDLE;
        end else if (init_done) begin
          state_next = ST_REGISTER;
        end
      end
      ST_REGISTER: begin
        // registration request lasts one cycle, then the card is ready
        if (go_remove_w) begin
          state_next = ST_IDLE;
        end else begin
          state_next = ST_READY;
        end
      end
      ST_READY: begin
        if (go_remove_w) begin
          state_next = ST_IDLE;
        end
      end
      ST_ONCE_DONE: begin
        // read once done; detection input has no effect here
        if (enable_reg) begin
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_BOOT;
      end
    endcase
    // disabled after start-up: ST_IDLE moves to ST_ONCE_DONE, ST_READY and ST_ONCE_DONE stay put, detect input ignored
    if (hold_disabled_w) begin
      state_next = in_idle_w ? ST_ONCE_DONE : state_reg;
    end
  end

  // state outputs follow the next state, so they line up with state_reg; presence follows enable_next
  assign start_next = next_init_w && !in_init_w;
  assign read_next = next_init_w || next_register_w || next_ready_w;
  assign regreq_next = in_init_w && next_register_w;
  assign present_next = enable_next && level_w;
  // events only while enabled; presence drops on the same edge as the enable
  assign ins_evt_next = enable_reg && insert_w;
  assign rem_evt_next = enable_reg && remove_w;
  // one short register per output, all cleared in reset
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_reg <= ST_BOOT;
    end else begin
      state_reg <= state_next;
    end
  end
  always_ff @(posedge core_clk) begin
    if (rst) begin
      start_reg <= 1'b0;
    end else begin
      start_reg <= start_next;
    end
  end
  always_ff @(posedge core_clk) begin
    if (rst) begin
      read_reg <= 1'b0;
    end else begin
      read_reg <= read_next;
    end
  end
  always_ff @(posedge core_clk) begin
    if (rst) begin
      regreq_reg <= 1'b0;
    end else begin
      regreq_reg <= regreq_next;
    end
  end
  always_ff @(posedge core_clk) begin
    if (rst) begin
      present_reg <= 1'b0;
    end else begin
      present_reg <= present_next;
    end
  end
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ins_evt_reg <= 1'b0;
    end else begin
      ins_evt_reg <= ins_evt_next;
    end
  end
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rem_evt_reg <= 1'b0;
    end else begin
      rem_evt_reg <= rem_evt_next;
    end
  end

  assign card_init_start = start_reg;
  assign card_read_enable = read_reg;
  assign net_register_req = regreq_reg;
  assign card_present = present_reg;
  assign card_inserted_evt = ins_evt_reg;
  assign card_removed_evt = rem_evt_reg;
  assign hot_plug_enabled = enable_reg;
  assign polarity_high = polarity_reg;
endmodule

/* File: verif/card_slot_model.sv */
`timescale 1ns/100ps
module card_slot_model (
  input wire logic card_in,
  output logic card_detect_in
);
  // detect switch closes while a card sits in the slot
  assign card_detect_in = card_in;
endmodule

/* File: verif/card_presence_ctrl_monitor.sv */
`timescale 1ns/100ps
module card_presence_ctrl_monitor (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic hot_plug_detect_enable_cmd,
  input wire logic hot_plug_detect_enable_val,
  input wire logic vendor_setting_cmd,
  input wire logic detect_polarity_select,
  input wire logic init_done,
  input wire logic card_init_start,
  input wire logic card_read_enable,
  input wire logic net_register_req,
  input wire logic card_present,
  input wire logic card_inserted_evt,
  input wire logic card_removed_evt,
  input wire logic hot_plug_enabled,
  input wire logic polarity_high
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  a_reset_defaults: assert property ($fell(rst) |-> !hot_plug_enabled && polarity_high)
    else $error("bad reset settings");
  a_disabled_silent: assert property (!hot_plug_enabled && !$past(hot_plug_enabled) |->
    !card_inserted_evt && !card_removed_evt) else $error("event while disabled");
  a_reg_after_read: assert property (net_register_req |-> $past(init_done))
    else $error("early registration");
  a_insert_starts: assert property (card_inserted_evt |-> ##[0:2] card_init_start)
    else $error("no init start");
  a_remove_stops: assert property (card_removed_evt |-> ##[0:1] !card_read_enable)
    else $error("reads not stopped");
  a_present_needs_en: assert property (card_present |-> hot_plug_enabled)
    else $error("present while disabled");
  a_pol_load: assert property (vendor_setting_cmd |=> polarity_high == $past(detect_polarity_select))
    else $error("polarity not loaded");
  a_en_load: assert property (hot_plug_detect_enable_cmd |=>
    hot_plug_enabled == $past(hot_plug_detect_enable_val)) else $error("enable not loaded");
  a_boot_read: assert property ($fell(rst) |=> card_init_start)
    else $error("no read at start-up");
  c_insert: cover property (card_inserted_evt);
  c_remove: cover property (card_removed_evt);
  c_register: cover property (net_register_req);
  c_disable: cover property ($fell(hot_plug_enabled));
endmodule
bind card_presence_ctrl card_presence_ctrl_monitor u_card_presence_ctrl_monitor (
  .core_clk(core_clk),
  .rst(rst),
  .hot_plug_detect_enable_cmd(hot_plug_detect_enable_cmd),
  .hot_plug_detect_enable_val(hot_plug_detect_enable_val),
  .vendor_setting_cmd(vendor_setting_cmd),
  .detect_polarity_select(detect_polarity_select),
  .init_done(init_done),
  .card_init_start(card_init_start),
  .card_read_enable(card_read_enable),
  .net_register_req(net_register_req),
  .card_present(card_present),
  .card_inserted_evt(card_inserted_evt),
  .card_removed_evt(card_removed_evt),
  .hot_plug_enabled(hot_plug_enabled),
  .polarity_high(polarity_high)
);

/* File: verif/card_presence_ctrl_tb_top.sv */
`timescale 1ns/100ps
module card_presence_ctrl_tb_top;
  logic core_clk = 0, rst = 1, card_in = 0, en_cmd = 0, en_val = 0, pol_cmd = 0, pol_sel = 1, init_done = 0;
  logic pin, start, rd_en, reg_req, present, ins, rem, hpe, polh;
  logic [7:0] n_init = 0, n_reg = 0, n_ins = 0, n_rem = 0;
  int n_mismatch = 0, total_checks = 0;
  initial forever #2 core_clk = ~core_clk;
  card_slot_model u_card_slot_model (.card_in(card_in), .card_detect_in(pin));
  card_presence_ctrl #(.FILTER_CYCLES(2)) u_card_presence_ctrl (.core_clk(core_clk), .rst(rst),
    .card_detect_in(pin), .hot_plug_detect_enable_cmd(en_cmd), .hot_plug_detect_enable_val(en_val),
    .vendor_setting_cmd(pol_cmd), .detect_polarity_select(pol_sel), .init_done(init_done),
    .card_init_start(start), .card_read_enable(rd_en), .net_register_req(reg_req), .card_present(present),
    .card_inserted_evt(ins), .card_removed_evt(rem), .hot_plug_enabled(hpe), .polarity_high(polh));
  // init engine answers one cycle after each start; pulse counters
  always @(posedge core_clk) begin
    init_done <= start;
    n_init <= n_init + {7'h0, start};
    n_reg <= n_reg + {7'h0, reg_req};
    n_ins <= n_ins + {7'h0, ins};
    n_rem <= n_rem + {7'h0, rem};
  end
  task check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task step(input int cyc);
    repeat (cyc) @(posedge core_clk);
  endtask
  task report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task t_boot;
    step(20);
    check({6'h0, hpe, polh}, 8'h01);
    check(n_init, 8'h01);
    check(n_reg, 8'h01);
    card_in <= 1'b1;
    step(20);
    check(n_ins, 8'h00);
    check(n_rem, 8'h00);
    check({6'h0, present, rd_en}, 8'h01);
    check(n_init, 8'h01);
    card_in <= 1'b0;
    step(20);
    $display("boot test done");
  endtask
  task t_enable;
    en_val <= 1'b1;
    en_cmd <= 1'b1;
    step(1);
    en_cmd <= 1'b0;
    step(20);
    check({6'h0, hpe, rd_en}, 8'h02);
    card_in <= 1'b1;
    step(20);
    check(n_ins, 8'h01);
    check(n_init, 8'h02);
    check(n_reg, 8'h02);
    check({6'h0, present, rd_en}, 8'h03);
    card_in <= 1'b0;
    step(20);
    check(n_rem, 8'h01);
    check({6'h0, present, rd_en}, 8'h00);
    $display("enable test done");
  endtask
  task t_polarity;
    pol_sel <= 1'b0;
    pol_cmd <= 1'b1;
    step(1);
    pol_cmd <= 1'b0;
    step(20);
    check({6'h0, polh, present}, 8'h01);
    card_in <= 1'b1;
    step(20);
    check({present, n_rem[6:0]}, 8'h02);
    $display("polarity test done");
  endtask
  task t_disable;
    en_val <= 1'b0;
    en_cmd <= 1'b1;
    step(1);
    en_cmd <= 1'b0;
    step(20);
    check({6'h0, hpe, rd_en}, 8'h00);
    card_in <= 1'b0;
    step(20);
    check(n_ins, 8'h02);
    check(n_init, 8'h03);
    check({6'h0, present, rd_en}, 8'h00);
    card_in <= 1'b1;
    step(20);
    check(n_rem, 8'h02);
    $display("disable test done");
  endtask
  task t_reset;
    rst <= 1'b1;
    step(16);
    rst <= 1'b0;
    step(20);
    check({6'h0, hpe, polh}, 8'h01);
    check(n_init, 8'h04);
    check(n_reg, 8'h04);
    check(n_ins, 8'h02);
    $display("reset test done");
  endtask
  initial begin
    step(16);
    rst <= 1'b0;
    t_boot;
    t_enable;
    t_polarity;
    t_disable;
    t_reset;
    report_and_stop;
  end
endmodule
